// File: dv/pfm_mux_checker_sva.sv
`timescale 1ns/1ns
`include "pfm_defines.vh"
module pfm_mux_checker (
	input wire                 ref_clk,
	input wire                 rst,
	input wire [`PFM_AW-1:0]   regAddr,
	input wire [7:0]           regWrData,
	input wire                 regWr,
	input wire                 regRd,
	input wire [7:0]           regRdData,
	input wire [`PFM_NPIN-1:0] pinIn,
	input wire [`PFM_NPIN-1:0] pinOut,
	input wire [`PFM_NPIN-1:0] pinOe,
	input wire [`PFM_NFN-1:0]  perOut,
	input wire [`PFM_NFN-1:0]  perOe,
	input wire [`PFM_NFN-1:0]  perIn,
	input wire [`PFM_NIRQ-1:0] extIrqIn,
	input wire [`PFM_NP4-1:0]  adcChanEn,
	input wire [`PFM_NCMP-1:0] cmpInEn
);
	// ****
	// Shadow copies, one edge ahead of outputs
	// ****
	logic       iselQ;
	logic       adcQ;
	logic [4:0] selQ;
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			iselQ <= 1'b0;
			adcQ  <= 1'b0;
			selQ  <= 5'h00;
		end else if (regWr) begin
			if (regAddr == `PFM_REG_PE2) iselQ <= regWrData[6];
			if (regAddr == `PFM_REG_P40) adcQ <= regWrData[7];
			if (regAddr == `PFM_REG_PB1) selQ <= regWrData[4:0];
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	chk_hiz_zero: assert property (
		regWr && regAddr < 5'h12 && regWrData[4:0] == 5'h00 |-> ##2 pinOe[$past(regAddr, 2)] == 1'b0)
		else $error("pin drives with select zero");
	chk_p22_reserved: assert property (
		regWr && regAddr == 5'h00 && !(regWrData[4:0] inside {5'h00, 5'h01, 5'h1E})
		|-> ##2 pinOe[0] == 1'b0) else $error("reserved code drives pin");
	chk_irq_route: assert property (
		extIrqIn[0] == ($past(iselQ) & $past(pinIn[17]))) else $error("interrupt zero wrong");
	chk_adc_ch0: assert property (
		adcChanEn[0] == $past(adcQ) && cmpInEn[0] == $past(adcQ)) else $error("analog zero wrong");
	chk_analog_read: assert property (
		regRd && regAddr == `PFM_REG_P40 |=> regRdData == {adcQ, 7'h00}) else $error("analog readback");
	chk_scl_path: assert property (
		$past(selQ) == 5'h0F |-> pinOe[6] == $past(perOe[32]) && pinOut[6] == $past(perOut[32])
		&& perIn[32] == $past(pinIn[6])) else $error("clock line path wrong");
	chk_scl_idle: assert property (
		$past(selQ) == 5'h00 |-> pinOe[6] == 1'b0 && perIn[32] == 1'b0) else $error("idle pin routed");
	chk_unmapped_rd: assert property (
		$past(regRd) && $past(regAddr) > 5'h1C |-> regRdData == 8'h00) else $error("unmapped read");
endmodule
bind pfm_pin_function_mux pfm_mux_checker u_chk (.ref_clk(ref_clk), .rst(rst),
	.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
	.regRdData(regRdData), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .perOut(perOut),
	.perOe(perOe), .perIn(perIn), .extIrqIn(extIrqIn), .adcChanEn(adcChanEn), .cmpInEn(cmpInEn));

// File: dv/pfm_periph_model.sv
`timescale 1ns/1ns
// ****
// Peripheral side, values change every cycle
// ****
module pfm_periph_model (
	input  wire         ref_clk,
	output logic [38:0] perOut,
	output logic [38:0] perOe
);
	// Pure inputs never ask to drive
	localparam logic [38:0] IN_ONLY = 39'h70_0011_E007;
	logic [38:0] lfsrQ = 39'h12_3456_789A;
	always @(posedge ref_clk) begin
		lfsrQ <= {lfsrQ[37:0], lfsrQ[38] ^ lfsrQ[34]};
	end
	assign perOut = lfsrQ;
	assign perOe = {lfsrQ[19:0], lfsrQ[38:20]} & ~IN_ONLY;
endmodule

// File: dv/tb_pfm_pin_function_mux.sv
`timescale 1ns/1ns
`include "pfm_defines.vh"
module tb_pfm_pin_function_mux;
	logic        ref_clk = 1'b0;
	logic        rst = 1'b1;
	logic [4:0]  regAddr = 5'h00;
	logic [7:0]  regWrData = 8'h00;
	logic        regWr = 1'b0;
	logic        regRd = 1'b0;
	logic [17:0] pinIn = 18'h00000;
	logic [17:0] prevPin;
	logic [38:0] prevOut;
	logic [38:0] prevOe;
	wire  [7:0]  regRdData;
	wire  [17:0] pinOut;
	wire  [17:0] pinOe;
	wire  [38:0] perOut;
	wire  [38:0] perOe;
	wire  [38:0] perIn;
	wire  [5:0]  extIrqIn;
	wire  [7:0]  adcChanEn;
	wire  [11:0] cmpInEn;
	int          fails = 0;
	int          testsRun = 0;
	int          cyc = 0;
	int          mdl [0:31];
	int          slot [0:7] = '{0, 4, 8, 2, 6, 10, 3, 7};
	logic [4:0]  a;
	logic [7:0]  d;
	logic [15:0] e;
	logic [7:0]  irqTab [0:10] = '{8'h02, 8'h0C, 8'h13, 8'h1C, 8'h32, 8'h4B, 8'h65, 8'h72,
		8'h7B, 8'h85, 8'h88};
	// Entries are pin index, select code, function index
	logic [15:0] fnTab [0:52] = '{16'h0042, 16'h0793, 16'h0841, 16'h09D4, 16'h0A95, 16'h0F92,
		16'h1040, 16'h1296, 16'h1791, 16'h1847, 16'h18CA, 16'h1A97, 16'h2048, 16'h20C9,
		16'h2319, 16'h2846, 16'h288E, 16'h28C9, 16'h2B1A, 16'h3045, 16'h308D, 16'h30C2,
		16'h3296, 16'h33E0, 16'h3844, 16'h388F, 16'h38E2, 16'h39D5, 16'h3BE1, 16'h4043,
		16'h41D4, 16'h4298, 16'h431B, 16'h49E5, 16'h5264, 16'h5848, 16'h58CB, 16'h5A95,
		16'h5ADC, 16'h604C, 16'h6090, 16'h6296, 16'h62DD, 16'h6843, 16'h6A9C, 16'h7044,
		16'h729E, 16'h7845, 16'h7A9D, 16'h8046, 16'h8263, 16'h829F, 16'h89E6};
	pfm_pin_function_mux uut (.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe), .perOut(perOut), .perOe(perOe),
		.perIn(perIn), .extIrqIn(extIrqIn), .adcChanEn(adcChanEn), .cmpInEn(cmpInEn));
	pfm_periph_model u_per (.ref_clk(ref_clk), .perOut(perOut), .perOe(perOe));
	always #50 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		pinIn <= 18'($urandom);
		prevPin <= pinIn;
		prevOut <= perOut;
		prevOe <= perOe;
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			fails++;
			results();
		end
	end
	// ****
	// Shared tasks
	// ****
	function automatic logic [7:0] wmask(input logic [4:0] r);
		if (r > 5'h11) return 8'h80;
		return 18'h3D24F >> r & 1 ? 8'h5F : 8'h1F;
	endfunction
	task chk(input logic [38:0] got, input logic [38:0] exp);
		testsRun++;
		if (got !== exp) begin
			fails++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask
	task wr(input logic [4:0] r, input logic [7:0] v);
		@(posedge ref_clk);
		regWr <= 1'b1;
		regAddr <= r;
		regWrData <= v;
		@(posedge ref_clk);
		regWr <= 1'b0;
	endtask
	task settle();
		@(posedge ref_clk);
		@(negedge ref_clk);
	endtask
	task rdAll();
		for (int r = 0; r < 32; r++) begin
			if (r < 26 || r > 28) begin
				@(posedge ref_clk);
				regRd <= 1'b1;
				regAddr <= 5'(r);
				@(posedge ref_clk);
				regRd <= 1'b0;
				@(negedge ref_clk);
				chk(regRdData, 39'(mdl[r]));
			end
		end
	endtask
	task results();
		$display("Comparisons %0d, mismatches %0d", testsRun, fails);
		if (fails == 0 && testsRun > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// ****
	// Main sequence
	// ****
	initial begin
		void'($urandom(65));
		repeat (4) @(posedge ref_clk);
		rst <= 1'b0;
		@(negedge ref_clk);
		chk(perIn, `PFM_FN_IDLE_HI);
		chk(pinOe, 18'h00000);
		rdAll();
		$display("Test done: reset");
		repeat (40) begin
			a = 5'($urandom_range(0, 28));
			if (a > 5'h19) a = a + 5'h03;
			d = 8'($urandom);
			wr(a, d);
			if (a < 5'h1A) mdl[a] = int'(d & wmask(a));
		end
		rdAll();
		for (int i = 0; i < 26; i++) begin
			wr(5'(i), 8'h00);
			mdl[i] = 0;
		end
		$display("Test done: registers");
		foreach (fnTab[i]) begin
			e = fnTab[i];
			wr(e[15:11], {3'b000, e[10:6]});
			settle();
			chk(perIn[e[5:0]], prevPin[e[15:11]]);
			chk(pinOe[e[15:11]], prevOe[e[5:0]]);
			if (prevOe[e[5:0]]) chk(pinOut[e[15:11]], prevOut[e[5:0]]);
			wr(e[15:11], 8'h00);
		end
		$display("Test done: routing");
		for (int i = 0; i < 18; i++) wr(5'(i), 8'h1F);
		settle();
		chk(pinOe, 18'h00000);
		chk(perIn, `PFM_FN_IDLE_HI);
		for (int i = 0; i < 18; i++) wr(5'(i), 8'h00);
		$display("Test done: reserved");
		foreach (irqTab[i]) begin
			d = irqTab[i];
			wr(d[7:3], 8'h40);
			settle();
			chk(extIrqIn, 6'(prevPin[d[7:3]]) << d[2:0]);
			wr(d[7:3], 8'h00);
		end
		$display("Test done: interrupts");
		for (int n = 0; n < 8; n++) begin
			wr(5'(18 + n), 8'hFF);
			settle();
			chk(adcChanEn, 39'(1) << n);
			chk(cmpInEn, 39'(1) << slot[n]);
			wr(5'(18 + n), 8'h00);
		end
		$display("Test done: analog");
		results();
	end
endmodule

// File: hdl/pfm_defines.vh
`ifndef PFM_DEFINES_VH
`define PFM_DEFINES_VH

// ****************************************
// Sizes
// ****************************************
`define PFM_AW          5
`define PFM_NPIN        18
`define PFM_NP4         8
`define PFM_NFN         39
`define PFM_NIRQ        6
`define PFM_NCMP        12

// ****************************************
// Register indices
// ****************************************
`define PFM_REG_P22     5'h00
`define PFM_REG_P23     5'h01
`define PFM_REG_P24     5'h02
`define PFM_REG_PA2     5'h03
`define PFM_REG_PA3     5'h04
`define PFM_REG_PB0     5'h05
`define PFM_REG_PB1     5'h06
`define PFM_REG_PB2     5'h07
`define PFM_REG_PB3     5'h08
`define PFM_REG_PB4     5'h09
`define PFM_REG_PB5     5'h0A
`define PFM_REG_PB6     5'h0B
`define PFM_REG_PB7     5'h0C
`define PFM_REG_PD3     5'h0D
`define PFM_REG_PD4     5'h0E
`define PFM_REG_PD5     5'h0F
`define PFM_REG_PD6     5'h10
`define PFM_REG_PE2     5'h11
`define PFM_REG_P40     5'h12
`define PFM_REG_P47     5'h19
`define PFM_REG_DRV0    5'h1A
`define PFM_REG_DRV2    5'h1C

// ****************************************
// Fields and reset values
// ****************************************
`define PFM_PSEL_MASK   8'h1F
`define PFM_INTERRUPT_ROUTE_BIT_BIT    6
`define PFM_INTERRUPT_ROUTE_BIT_MASK   8'h40
`define PFM_ANALOG_ROUTE_BIT_BIT    7
`define PFM_ANALOG_ROUTE_BIT_MASK   8'h80
`define PFM_PFS_RESET   8'h00
`define PFM_FN_NONE     6'h3F
`define PFM_IRQ_NONE    3'h7

// ****************************************
// Peripheral function indices
// ****************************************
`define PFM_FN_T5U      6'd0
`define PFM_FN_T5V      6'd1
`define PFM_FN_T5W      6'd2
`define PFM_FN_TC0A     6'd3
`define PFM_FN_TC0B     6'd4
`define PFM_FN_TC0C     6'd5
`define PFM_FN_TC0D     6'd6
`define PFM_FN_TC1A     6'd7
`define PFM_FN_TC1B     6'd8
`define PFM_FN_TC2A     6'd9
`define PFM_FN_TC2B     6'd10
`define PFM_FN_TC3A     6'd11
`define PFM_FN_TC3C     6'd12
`define PFM_FN_CLKA     6'd13
`define PFM_FN_CLKB     6'd14
`define PFM_FN_CLKC     6'd15
`define PFM_FN_CLKD     6'd16
`define PFM_FN_CMPO0    6'd17
`define PFM_FN_CMPO1    6'd18
`define PFM_FN_CMPO2    6'd19
`define PFM_FN_CLOCK_ACCURACY_REF_IN   6'd20
`define PFM_FN_S5TX     6'd21
`define PFM_FN_S5RX     6'd22
`define PFM_FN_S5FS     6'd23
`define PFM_FN_S5CK     6'd24
`define PFM_FN_S12FS    6'd25
`define PFM_FN_S12TX    6'd26
`define PFM_FN_S12CK    6'd27
`define PFM_FN_S1TX     6'd28
`define PFM_FN_S1RX     6'd29
`define PFM_FN_S1CK     6'd30
`define PFM_FN_S1FS     6'd31
`define PFM_FN_I2CSCL   6'd32
`define PFM_FN_I2CSDA   6'd33
`define PFM_FN_ADMON    6'd34
`define PFM_FN_ADSTART  6'd35
`define PFM_FN_ADTRIG   6'd36
`define PFM_FN_OEIN8    6'd37
`define PFM_FN_OEIN10   6'd38
`define PFM_FN_IDLE_HI  39'h70_8280_0000

`endif

// File: hdl/pfm_pin_function_mux.v
`timescale 1ns/1ns
`include "pfm_defines.vh"
// What this block does
// - Five-bit select per pin, zero means Hi-Z
// - Interrupt bit routes pin to its interrupt
// - Analog bit makes pin an analog input
// - Port 4 pins feed ADC channel and comparator
// - P22 selects timer5 W capture, comparator2
// - P23 selects T5V, clock ref, serial5 tx, comparator1_out
// - P24 selects T5U, serial5 rx, comparator0
// - PA2 selects T1A, T2B, serial5 flow/select
// - PA3 selects T1B, T2A, serial12 flow/select
// - PB0 selects T0D, clock B, T2A, serial12 tx
// - PB1 selects T0C, clock A, T5W, s5 rx, SCL
// - PB2 selects T0B, clock C, monitor, s5 tx, SDA
// - PB3 selects T0A, clock ref, s5/s12 clock
// - PB5 ADC trigger, PB4 output-enable input 8
// - PB6 selects T1B, T3A, s5 tx, s1 tx
// - PB7 selects T3C, clock D, s5 rx, s1 rx
// - PD3-PD6 timer0 channels, serial1, ADC start
// - PE2 output-enable input 10, interrupt 0
// - PB1/PB4/PB7/PA2 feed interrupts 2/3/5/4
// - PD4/PD5/PD6 feed interrupts 2/3/5
module pfm_pin_function_mux (
	input  wire                    ref_clk,
	input  wire                    rst,
	input  wire [`PFM_AW-1:0]      regAddr,
	input  wire [7:0]              regWrData,
	input  wire                    regWr,
	input  wire                    regRd,
	output reg  [7:0]              regRdData,
	input  wire [`PFM_NPIN-1:0]    pinIn,
	output reg  [`PFM_NPIN-1:0]    pinOut,
	output reg  [`PFM_NPIN-1:0]    pinOe,
	input  wire [`PFM_NFN-1:0]     perOut,
	input  wire [`PFM_NFN-1:0]     perOe,
	output reg  [`PFM_NFN-1:0]     perIn,
	output reg  [`PFM_NIRQ-1:0]    extIrqIn,
	output reg  [`PFM_NP4-1:0]     adcChanEn,
	output reg  [`PFM_NCMP-1:0]    cmpInEn
);

	localparam NREG = `PFM_NPIN + `PFM_NP4;

	// ****************************************
	// Lookup tables
	// ****************************************
	function [5:0] fnOf(input [4:0] pin, input [4:0] code);
		begin
			case ({pin, code})
				{`PFM_REG_P22, 5'h01}: fnOf = `PFM_FN_T5W;
				{`PFM_REG_P22, 5'h1E}: fnOf = `PFM_FN_CMPO2;
				{`PFM_REG_P23, 5'h01}: fnOf = `PFM_FN_T5V;
				{`PFM_REG_P23, 5'h07}: fnOf = `PFM_FN_CLOCK_ACCURACY_REF_IN;
				{`PFM_REG_P23, 5'h0A}: fnOf = `PFM_FN_S5TX;
				{`PFM_REG_P23, 5'h1E}: fnOf = `PFM_FN_CMPO1;
				{`PFM_REG_P24, 5'h01}: fnOf = `PFM_FN_T5U;
				{`PFM_REG_P24, 5'h0A}: fnOf = `PFM_FN_S5RX;
				{`PFM_REG_P24, 5'h1E}: fnOf = `PFM_FN_CMPO0;
				{`PFM_REG_PA2, 5'h01}: fnOf = `PFM_FN_TC1A;
				{`PFM_REG_PA2, 5'h03}: fnOf = `PFM_FN_TC2B;
				{`PFM_REG_PA2, 5'h0A}: fnOf = `PFM_FN_S5FS;
				{`PFM_REG_PA3, 5'h01}: fnOf = `PFM_FN_TC1B;
				{`PFM_REG_PA3, 5'h03}: fnOf = `PFM_FN_TC2A;
				{`PFM_REG_PA3, 5'h0C}: fnOf = `PFM_FN_S12FS;
				{`PFM_REG_PB0, 5'h01}: fnOf = `PFM_FN_TC0D;
				{`PFM_REG_PB0, 5'h02}: fnOf = `PFM_FN_CLKB;
				{`PFM_REG_PB0, 5'h03}: fnOf = `PFM_FN_TC2A;
				{`PFM_REG_PB0, 5'h0C}: fnOf = `PFM_FN_S12TX;
				{`PFM_REG_PB1, 5'h01}: fnOf = `PFM_FN_TC0C;
				{`PFM_REG_PB1, 5'h02}: fnOf = `PFM_FN_CLKA;
				{`PFM_REG_PB1, 5'h03}: fnOf = `PFM_FN_T5W;
				{`PFM_REG_PB1, 5'h0A}: fnOf = `PFM_FN_S5RX;
				{`PFM_REG_PB1, 5'h0F}: fnOf = `PFM_FN_I2CSCL;
				{`PFM_REG_PB2, 5'h01}: fnOf = `PFM_FN_TC0B;
				{`PFM_REG_PB2, 5'h02}: fnOf = `PFM_FN_CLKC;
				{`PFM_REG_PB2, 5'h03}: fnOf = `PFM_FN_ADMON;
				{`PFM_REG_PB2, 5'h07}: fnOf = `PFM_FN_S5TX;
				{`PFM_REG_PB2, 5'h0F}: fnOf = `PFM_FN_I2CSDA;
				{`PFM_REG_PB3, 5'h01}: fnOf = `PFM_FN_TC0A;
				{`PFM_REG_PB3, 5'h07}: fnOf = `PFM_FN_CLOCK_ACCURACY_REF_IN;
				{`PFM_REG_PB3, 5'h0A}: fnOf = `PFM_FN_S5CK;
				{`PFM_REG_PB3, 5'h0C}: fnOf = `PFM_FN_S12CK;
				{`PFM_REG_PB4, 5'h07}: fnOf = `PFM_FN_OEIN8;
				{`PFM_REG_PB5, 5'h09}: fnOf = `PFM_FN_ADTRIG;
				{`PFM_REG_PB6, 5'h01}: fnOf = `PFM_FN_TC1B;
				{`PFM_REG_PB6, 5'h03}: fnOf = `PFM_FN_TC3A;
				{`PFM_REG_PB6, 5'h0A}: fnOf = `PFM_FN_S5TX;
				{`PFM_REG_PB6, 5'h0B}: fnOf = `PFM_FN_S1TX;
				{`PFM_REG_PB7, 5'h01}: fnOf = `PFM_FN_TC3C;
				{`PFM_REG_PB7, 5'h02}: fnOf = `PFM_FN_CLKD;
				{`PFM_REG_PB7, 5'h0A}: fnOf = `PFM_FN_S5RX;
				{`PFM_REG_PB7, 5'h0B}: fnOf = `PFM_FN_S1RX;
				{`PFM_REG_PD3, 5'h01}: fnOf = `PFM_FN_TC0A;
				{`PFM_REG_PD3, 5'h0A}: fnOf = `PFM_FN_S1TX;
				{`PFM_REG_PD4, 5'h01}: fnOf = `PFM_FN_TC0B;
				{`PFM_REG_PD4, 5'h0A}: fnOf = `PFM_FN_S1CK;
				{`PFM_REG_PD5, 5'h01}: fnOf = `PFM_FN_TC0C;
				{`PFM_REG_PD5, 5'h0A}: fnOf = `PFM_FN_S1RX;
				{`PFM_REG_PD6, 5'h01}: fnOf = `PFM_FN_TC0D;
				{`PFM_REG_PD6, 5'h09}: fnOf = `PFM_FN_ADSTART;
				{`PFM_REG_PD6, 5'h0A}: fnOf = `PFM_FN_S1FS;
				{`PFM_REG_PE2, 5'h07}: fnOf = `PFM_FN_OEIN10;
				// Code zero and every unlisted code land here
				default: fnOf = `PFM_FN_NONE;
			endcase
		end
	endfunction

	function [2:0] irqOf(input [4:0] pin);
		begin
			case (pin)
				`PFM_REG_P22: irqOf = 3'd2;
				`PFM_REG_P23: irqOf = 3'd4;
				`PFM_REG_P24: irqOf = 3'd3;
				`PFM_REG_PA2: irqOf = 3'd4;
				`PFM_REG_PB1: irqOf = 3'd2;
				`PFM_REG_PB4: irqOf = 3'd3;
				`PFM_REG_PB7: irqOf = 3'd5;
				`PFM_REG_PD4: irqOf = 3'd2;
				`PFM_REG_PD5: irqOf = 3'd3;
				`PFM_REG_PD6: irqOf = 3'd5;
				`PFM_REG_PE2: irqOf = 3'd0;
				default:      irqOf = `PFM_IRQ_NONE;
			endcase
		end
	endfunction

	// Comparator input slot is comparator * 4 + input number
	function [3:0] cmpIdx(input [2:0] k);
		begin
			case (k)
				3'd0:    cmpIdx = 4'd0;
				3'd1:    cmpIdx = 4'd4;
				3'd2:    cmpIdx = 4'd8;
				3'd3:    cmpIdx = 4'd2;
				3'd4:    cmpIdx = 4'd6;
				3'd5:    cmpIdx = 4'd10;
				3'd6:    cmpIdx = 4'd3;
				default: cmpIdx = 4'd7;
			endcase
		end
	endfunction

	// Bits a pin does not implement stay zero
	function [7:0] wrMask(input [4:0] idx);
		begin
			if (idx >= `PFM_REG_P40)
				wrMask = `PFM_ANALOG_ROUTE_BIT_MASK;
			else if (irqOf(idx) != `PFM_IRQ_NONE)
				wrMask = `PFM_PSEL_MASK | `PFM_INTERRUPT_ROUTE_BIT_MASK;
			else
				wrMask = `PFM_PSEL_MASK;
		end
	endfunction

	// ****************************************
	// Function registers
	// ****************************************
	reg  [7:0]                  pfs_q [0:NREG-1];
	wire [6*`PFM_NPIN-1:0]      pinFn;
	reg  [`PFM_NFN-1:0]         perHit;
	reg  [`PFM_NFN-1:0]         perLvl;
	reg  [`PFM_NIRQ-1:0]        irqD;
	reg  [`PFM_NCMP-1:0]        cmpD;
	reg  [7:0]                  rdD;
	wire [23:0]                 drvStat;
	// Each process owns its loop index so no process wakes another
	integer                     i;
	integer                     pi;
	integer                     ai;

	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			for (i = 0; i < NREG; i = i + 1)
				pfs_q[i] <= `PFM_PFS_RESET;
		end else if (regWr && regAddr <= `PFM_REG_P47) begin
			pfs_q[regAddr] <= regWrData & wrMask(regAddr);
		end
	end

	// ****************************************
	// Register read
	// ****************************************
	assign drvStat = {6'h00, pinOe};

	always @* begin
		rdD = 8'h00;
		if (regAddr <= `PFM_REG_P47)
			rdD = pfs_q[regAddr];
		else if (regAddr <= `PFM_REG_DRV2)
			rdD = drvStat[8*(regAddr - `PFM_REG_DRV0) +: 8];
	end

	// Data stand only in the cycle after the strobe
	always @(posedge ref_clk or posedge rst) begin
		if (rst)
			regRdData <= 8'h00;
		else
			regRdData <= regRd ? rdD : 8'h00;
	end

	// ****************************************
	// Pin output side
	// ****************************************
	genvar gp;
	generate
		for (gp = 0; gp < `PFM_NPIN; gp = gp + 1) begin : g_pin
			localparam [4:0] PIDX = gp;
			wire [5:0] fn  = fnOf(PIDX, pfs_q[gp][4:0]);
			wire       hit = (fn != `PFM_FN_NONE);
			assign pinFn[6*gp +: 6] = fn;
			// Without a function the pin floats
			always @(posedge ref_clk or posedge rst) begin
				if (rst) begin
					pinOe[gp]  <= 1'b0;
					pinOut[gp] <= 1'b0;
				end else begin
					pinOe[gp]  <= hit ? perOe[fn] : 1'b0;
					pinOut[gp] <= hit ? perOut[fn] : 1'b0;
				end
			end
		end
	endgenerate

	// ****************************************
	// Peripheral and interrupt input side
	// ****************************************
	always @* begin
		perHit = {`PFM_NFN{1'b0}};
		perLvl = {`PFM_NFN{1'b0}};
		irqD   = {`PFM_NIRQ{1'b0}};
		for (pi = 0; pi < `PFM_NPIN; pi = pi + 1) begin
			if (pinFn[6*pi +: 6] != `PFM_FN_NONE) begin
				perHit[pinFn[6*pi +: 6]] = 1'b1;
				perLvl[pinFn[6*pi +: 6]] = perLvl[pinFn[6*pi +: 6]] | pinIn[pi];
			end
			if (irqOf(pi[4:0]) != `PFM_IRQ_NONE && pfs_q[pi][`PFM_INTERRUPT_ROUTE_BIT_BIT])
				irqD[irqOf(pi[4:0])] = irqD[irqOf(pi[4:0])] | pinIn[pi];
		end
	end

	// Unrouted active-low inputs idle high so no false trigger
	always @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			perIn    <= `PFM_FN_IDLE_HI;
			extIrqIn <= {`PFM_NIRQ{1'b0}};
		end else begin
			perIn    <= (perHit & perLvl) | (~perHit & `PFM_FN_IDLE_HI);
			extIrqIn <= irqD;
		end
	end

	// ****************************************
	// Analog side
	// ****************************************
	always @* begin
		cmpD = {`PFM_NCMP{1'b0}};
		for (ai = 0; ai < `PFM_NP4; ai = ai + 1)
			cmpD[cmpIdx(ai[2:0])] = pfs_q[`PFM_REG_P40 + ai][`PFM_ANALOG_ROUTE_BIT_BIT];
	end

	genvar ga;
	generate
		for (ga = 0; ga < `PFM_NP4; ga = ga + 1) begin : g_ana
			always @(posedge ref_clk or posedge rst) begin
				if (rst)
					adcChanEn[ga] <= 1'b0;
				else
					adcChanEn[ga] <= pfs_q[`PFM_NPIN + ga][`PFM_ANALOG_ROUTE_BIT_BIT];
			end
		end
	endgenerate

	always @(posedge ref_clk or posedge rst) begin
		if (rst)
			cmpInEn <= {`PFM_NCMP{1'b0}};
		else
			cmpInEn <= cmpD;
	end

endmodule
